// >>> hw/pll_gpio_pkg.sv
// Constants, register map and ratio decoding for the PLL ratio and pin1 mux block
//
// Summary of operation
// [RULE1] PLL runs only while pll_power_on is 1; resets to 0.
// [RULE2] Software programs ratio_integer only with values 6 to 12; resets to 1000.
// [RULE3] ratio_fraction is joined from 6 high, 9 middle and 9 low register bits.
// [RULE4] input_halver set divides the master clock by two ahead of the PLL.
// [RULE5] PLL output passes a fixed divide by four, then system_clock_divider.
// [RULE6] Software derives ratio_integer and ratio_fraction from the wanted ratio.
// [RULE7] Software should aim the PLL output near 90 MHz, integer ratio 8 best.
// [RULE8] pin1_function_select picks input, status flags, PLL clock, lock or constants.
// [RULE9] pin1_invert set inverts the driven pin1 level.
// [RULE10] clock_out_divider divides the pin1 PLL clock by one to four.
// [RULE11] After reset pin1 is an input.
// [RULE12] Pin1 as input serves as control select or jack input by mode pin.
// [RULE13] In three-wire mode pin1 is always the control select input.
// [RULE14] Second and third line-input pins serve as jack detection inputs.
// [RULE15] A clock derived from the master clock can leave on pin1.
// [RULE16] core_clock_source picks master clock at 0, PLL path at 1; resets 1.
// [RULE17] system_clock_divider divides by 1, 1.5, 2, 3, 4, 6, 8 or 12; resets 010.
// [RULE18] Pin1 output is combinational from its source, inversion applied last.
package pll_gpio_pkg;

   // ----------------------------------------------------------------
   // Register addresses
   // ----------------------------------------------------------------
   localparam logic [6:0] ADDR_POWER_MGMT = 7'h01;
   localparam logic [6:0] ADDR_CLOCK_CTRL = 7'h06;
   localparam logic [6:0] ADDR_PIN_FUNC = 7'h08;
   localparam logic [6:0] ADDR_INT_RATIO = 7'h24;
   localparam logic [6:0] ADDR_FRAC_HIGH = 7'h25;
   localparam logic [6:0] ADDR_FRAC_MID = 7'h26;
   localparam logic [6:0] ADDR_FRAC_LOW = 7'h27;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [8:0] RST_POWER_MGMT = 9'h000;
   localparam logic [8:0] RST_CLOCK_CTRL = 9'h140;
   localparam logic [8:0] RST_PIN_FUNC = 9'h000;
   localparam logic [8:0] RST_INT_RATIO = 9'h008;
   localparam logic [8:0] RST_FRAC_HIGH = 9'h00c;
   localparam logic [8:0] RST_FRAC_MID = 9'h093;
   localparam logic [8:0] RST_FRAC_LOW = 9'h0e9;
   localparam logic [8:0] READ_UNMAPPED = 9'h000;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int PLL_ON_BIT = 5;
   localparam int HALVER_BIT = 4;
   localparam int INT_MSB = 3;
   localparam int CORE_SRC_BIT = 8;
   localparam int SYSDIV_MSB = 7;
   localparam int SYSDIV_LSB = 5;
   localparam int SEL_MSB = 2;
   localparam int INVERT_BIT = 3;
   localparam int OPDIV_MSB = 5;
   localparam int OPDIV_LSB = 4;
   localparam int FRAC_HIGH_MSB = 5;
   localparam int FRAC_PART_MSB = 8;

   // ----------------------------------------------------------------
   // Pin1 function codes
   // ----------------------------------------------------------------
   localparam logic [2:0] FN_INPUT = 3'h0;
   localparam logic [2:0] FN_RESERVED = 3'h1;
   localparam logic [2:0] FN_TEMP_OK = 3'h2;
   localparam logic [2:0] FN_MUTE = 3'h3;
   localparam logic [2:0] FN_PLL_CLK = 3'h4;
   localparam logic [2:0] FN_PLL_LOCK = 3'h5;
   localparam logic [2:0] FN_LOW = 3'h6;
   localparam logic [2:0] FN_HIGH = 3'h7;

   // ----------------------------------------------------------------
   // Dividers, counted in half steps so that 1.5 is exact
   // ----------------------------------------------------------------
   localparam logic [4:0] RATIO2_FIXED_PLL = 5'h08;
   localparam logic [4:0] RATIO2_STEP = 5'h02;
   localparam int SYNC_W = 4;
   localparam int PIN_IDX_PIN1 = 0;
   localparam int PIN_IDX_MODE = 1;
   localparam int PIN_IDX_LINE2 = 2;
   localparam int PIN_IDX_LINE3 = 3;

   function automatic logic [4:0] system_clock_ratio2(input logic [2:0] code);
      case (code)
         3'h0: system_clock_ratio2 = 5'h02;
         3'h1: system_clock_ratio2 = 5'h03;
         3'h2: system_clock_ratio2 = 5'h04;
         3'h3: system_clock_ratio2 = 5'h06;
         3'h4: system_clock_ratio2 = 5'h08;
         3'h5: system_clock_ratio2 = 5'h0c;
         3'h6: system_clock_ratio2 = 5'h10;
         default: system_clock_ratio2 = 5'h18;
      endcase
   endfunction

   function automatic logic [4:0] opclk_ratio2(input logic [1:0] code);
      case (code)
         2'h0: opclk_ratio2 = 5'h02;
         2'h1: opclk_ratio2 = 5'h04;
         2'h2: opclk_ratio2 = 5'h06;
         default: opclk_ratio2 = 5'h08;
      endcase
   endfunction

endpackage

// >>> hw/tick_div_if.sv
// Interface carrying a tick stream and its ratio into a tick divider
`timescale 1ns/10ps
interface tick_div_if;
   logic tick_in;
   logic [4:0] ratio2;
   logic tick_out;
   modport src (output tick_in, output ratio2, input tick_out);
   modport div (input tick_in, input ratio2, output tick_out);
endinterface

// >>> hw/pin_sync.sv
// Three-stage synchroniser with agreement filter for pin inputs
`timescale 1ns/10ps
module pin_sync #(
   parameter int W = pll_gpio_pkg::SYNC_W
) (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic clk_en,
   input wire logic [W-1:0] pin,
   output logic [W-1:0] level
);
   logic [W-1:0] s1_r, s2_r, s3_r, level_r;
   logic [W-1:0] s1_nxt, s2_nxt, s3_nxt, level_nxt;

   // ----------------------------------------------------------------
   // Per-bit stages
   // ----------------------------------------------------------------
   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_bit
         always_comb begin
            s1_nxt[i] = pin[i];
            s2_nxt[i] = s1_r[i];
            s3_nxt[i] = s2_r[i];
            // Only stages two and three are compared; stage one may be metastable
            level_nxt[i] = (s2_r[i] == s3_r[i]) ? s3_r[i] : level_r[i];
         end
      end
   endgenerate

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         s1_r <= '0;
         s2_r <= '0;
         s3_r <= '0;
         level_r <= '0;
      end else if (clk_en) begin
         s1_r <= s1_nxt;
         s2_r <= s2_nxt;
         s3_r <= s3_nxt;
         level_r <= level_nxt;
      end
   end

   assign level = level_r;
endmodule

// >>> hw/tick_divider.sv
// Half-step accumulating divider for tick streams
`timescale 1ns/10ps
module tick_divider (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic clk_en,
   tick_div_if.div port
);
   logic [4:0] acc_r, acc_nxt;
   logic out_r, out_nxt;
   logic [5:0] sum;
   logic [5:0] lim;

   // ----------------------------------------------------------------
   // Each input tick adds two half steps; one output per ratio2 steps
   // ----------------------------------------------------------------
   always_comb begin
      lim = (port.ratio2 == 5'h00) ? {1'b0, pll_gpio_pkg::RATIO2_STEP} : {1'b0, port.ratio2};
      sum = {1'b0, acc_r} + {1'b0, pll_gpio_pkg::RATIO2_STEP};
      acc_nxt = acc_r;
      out_nxt = 1'b0;
      if (port.tick_in) begin
         if (sum >= lim) begin
            acc_nxt = 5'(sum - lim); // [RULE17]
            out_nxt = 1'b1;
         end else begin
            acc_nxt = sum[4:0];
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         acc_r <= 5'h00;
         out_r <= 1'b0;
      end else if (clk_en) begin
         acc_r <= acc_nxt;
         out_r <= out_nxt;
      end
   end

   assign port.tick_out = out_r;
endmodule

// >>> hw/pll_ratio_and_gpio_pin_mux.sv
// Clock control registers, PLL ratio outputs and pin1 function mux
`timescale 1ns/10ps
module pll_ratio_and_gpio_pin_mux (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic clk_en,
   input wire logic reg_wr_en,
   input wire logic reg_rd_en,
   input wire logic [6:0] reg_addr,
   input wire logic [8:0] reg_wdata,
   output logic [8:0] reg_rdata,
   output logic pll_power_on,
   output logic input_halver,
   output logic [3:0] ratio_integer,
   output logic [23:0] ratio_fraction,
   output logic pll_ref_tick,
   input wire logic pll_out_tick,
   input wire logic pll_lock,
   input wire logic temp_ok,
   input wire logic auto_mute_flag,
   output logic core_clock_source,
   output logic system_clock_tick,
   input wire logic pin1_in,
   output logic pin1_out,
   output logic pin1_oe,
   input wire logic mode_pin,
   input wire logic line2_pin,
   input wire logic line3_pin,
   output logic control_select_n,
   output logic jack_pin1,
   output logic jack_pin1_valid,
   output logic jack_pin2,
   output logic jack_pin3
);

   // ----------------------------------------------------------------
   // Register file
   // ----------------------------------------------------------------
   logic [8:0] power_management_one_r, power_management_one_nxt;
   logic [8:0] clock_control_r, clock_control_nxt;
   logic [8:0] pin_function_control_r, pin_function_control_nxt;
   logic [8:0] pll_integer_ratio_r, pll_integer_ratio_nxt;
   logic [8:0] pll_fraction_high_r, pll_fraction_high_nxt;
   logic [8:0] pll_fraction_mid_r, pll_fraction_mid_nxt;
   logic [8:0] pll_fraction_low_r, pll_fraction_low_nxt;
   logic [8:0] rdata_r, rdata_nxt;

   always_comb begin
      power_management_one_nxt = power_management_one_r;
      clock_control_nxt = clock_control_r;
      pin_function_control_nxt = pin_function_control_r;
      pll_integer_ratio_nxt = pll_integer_ratio_r;
      pll_fraction_high_nxt = pll_fraction_high_r;
      pll_fraction_mid_nxt = pll_fraction_mid_r;
      pll_fraction_low_nxt = pll_fraction_low_r;
      rdata_nxt = rdata_r;
      if (reg_wr_en) begin
         case (reg_addr)
            pll_gpio_pkg::ADDR_POWER_MGMT: power_management_one_nxt = reg_wdata;
            pll_gpio_pkg::ADDR_CLOCK_CTRL: clock_control_nxt = reg_wdata;
            pll_gpio_pkg::ADDR_PIN_FUNC: pin_function_control_nxt = reg_wdata;
            // Ratio range is left to software; any value is stored as written
            pll_gpio_pkg::ADDR_INT_RATIO: pll_integer_ratio_nxt = reg_wdata; // [RULE2]
            pll_gpio_pkg::ADDR_FRAC_HIGH: pll_fraction_high_nxt = reg_wdata;
            pll_gpio_pkg::ADDR_FRAC_MID: pll_fraction_mid_nxt = reg_wdata;
            pll_gpio_pkg::ADDR_FRAC_LOW: pll_fraction_low_nxt = reg_wdata;
            default: ;
         endcase
      end
      if (reg_rd_en) begin
         case (reg_addr)
            pll_gpio_pkg::ADDR_POWER_MGMT: rdata_nxt = power_management_one_r;
            pll_gpio_pkg::ADDR_CLOCK_CTRL: rdata_nxt = clock_control_r;
            pll_gpio_pkg::ADDR_PIN_FUNC: rdata_nxt = pin_function_control_r;
            pll_gpio_pkg::ADDR_INT_RATIO: rdata_nxt = pll_integer_ratio_r;
            pll_gpio_pkg::ADDR_FRAC_HIGH: rdata_nxt = pll_fraction_high_r;
            pll_gpio_pkg::ADDR_FRAC_MID: rdata_nxt = pll_fraction_mid_r;
            pll_gpio_pkg::ADDR_FRAC_LOW: rdata_nxt = pll_fraction_low_r;
            default: rdata_nxt = pll_gpio_pkg::READ_UNMAPPED;
         endcase
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         power_management_one_r <= pll_gpio_pkg::RST_POWER_MGMT; // [RULE1]
         clock_control_r <= pll_gpio_pkg::RST_CLOCK_CTRL; // [RULE16] [RULE17]
         pin_function_control_r <= pll_gpio_pkg::RST_PIN_FUNC; // [RULE11]
         pll_integer_ratio_r <= pll_gpio_pkg::RST_INT_RATIO;
         pll_fraction_high_r <= pll_gpio_pkg::RST_FRAC_HIGH;
         pll_fraction_mid_r <= pll_gpio_pkg::RST_FRAC_MID;
         pll_fraction_low_r <= pll_gpio_pkg::RST_FRAC_LOW;
         rdata_r <= pll_gpio_pkg::READ_UNMAPPED;
      end else if (clk_en) begin
         power_management_one_r <= power_management_one_nxt;
         clock_control_r <= clock_control_nxt;
         pin_function_control_r <= pin_function_control_nxt;
         pll_integer_ratio_r <= pll_integer_ratio_nxt;
         pll_fraction_high_r <= pll_fraction_high_nxt;
         pll_fraction_mid_r <= pll_fraction_mid_nxt;
         pll_fraction_low_r <= pll_fraction_low_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   assign reg_rdata = rdata_r;

   // ----------------------------------------------------------------
   // Field decode
   // ----------------------------------------------------------------
   logic [2:0] fn_sel;
   logic fn_invert;
   logic [1:0] opdiv_code;
   logic [2:0] sysdiv_code;

   assign pll_power_on = power_management_one_r[pll_gpio_pkg::PLL_ON_BIT]; // [RULE1]
   assign input_halver = pll_integer_ratio_r[pll_gpio_pkg::HALVER_BIT];
   assign ratio_integer = pll_integer_ratio_r[pll_gpio_pkg::INT_MSB:0];
   assign ratio_fraction = {pll_fraction_high_r[pll_gpio_pkg::FRAC_HIGH_MSB:0],
                            pll_fraction_mid_r[pll_gpio_pkg::FRAC_PART_MSB:0],
                            pll_fraction_low_r[pll_gpio_pkg::FRAC_PART_MSB:0]}; // [RULE3]
   assign core_clock_source = clock_control_r[pll_gpio_pkg::CORE_SRC_BIT];
   assign sysdiv_code = clock_control_r[pll_gpio_pkg::SYSDIV_MSB:pll_gpio_pkg::SYSDIV_LSB];
   assign fn_sel = pin_function_control_r[pll_gpio_pkg::SEL_MSB:0];
   assign fn_invert = pin_function_control_r[pll_gpio_pkg::INVERT_BIT];
   assign opdiv_code = pin_function_control_r[pll_gpio_pkg::OPDIV_MSB:pll_gpio_pkg::OPDIV_LSB];

   // ----------------------------------------------------------------
   // Master clock prescaler toward the PLL
   // ----------------------------------------------------------------
   logic halve_phase_r, halve_phase_nxt;

   always_comb begin
      halve_phase_nxt = halve_phase_r;
      if (pll_power_on && input_halver) begin
         halve_phase_nxt = ~halve_phase_r;
      end else begin
         halve_phase_nxt = 1'b0;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         halve_phase_r <= 1'b0;
      end else if (clk_en) begin
         halve_phase_r <= halve_phase_nxt;
      end
   end

   // While the PLL is on, every master cycle is a reference tick; halving keeps every second one
   assign pll_ref_tick = pll_power_on & (~input_halver | halve_phase_r); // [RULE4] [RULE1]

   // ----------------------------------------------------------------
   // PLL output path: fixed divide by four, then core and pin dividers
   // ----------------------------------------------------------------
   tick_div_if pll_fixed_if();
   tick_div_if system_clock_if();
   tick_div_if opclk_if();

   logic pll_tick_gated;
   // A PLL that is off produces no ticks even if the model keeps pulsing
   assign pll_tick_gated = pll_out_tick & pll_power_on; // [RULE1]

   assign pll_fixed_if.tick_in = pll_tick_gated;
   assign pll_fixed_if.ratio2 = pll_gpio_pkg::RATIO2_FIXED_PLL; // [RULE5]

   tick_divider u_pll_fixed (
      .ref_clk(ref_clk),
      .reset(reset),
      .clk_en(clk_en),
      .port(pll_fixed_if)
   );

   // Master clock ticks every cycle, PLL path ticks after the fixed divider
   assign system_clock_if.tick_in = core_clock_source ? pll_fixed_if.tick_out : 1'b1; // [RULE16]
   assign system_clock_if.ratio2 = pll_gpio_pkg::system_clock_ratio2(sysdiv_code); // [RULE17] [RULE5]

   tick_divider u_system_clock (
      .ref_clk(ref_clk),
      .reset(reset),
      .clk_en(clk_en),
      .port(system_clock_if)
   );

   assign system_clock_tick = system_clock_if.tick_out;

   assign opclk_if.tick_in = pll_fixed_if.tick_out;
   assign opclk_if.ratio2 = pll_gpio_pkg::opclk_ratio2(opdiv_code); // [RULE10]

   tick_divider u_opclk (
      .ref_clk(ref_clk),
      .reset(reset),
      .clk_en(clk_en),
      .port(opclk_if)
   );

   // Square wave for pin1: toggles on each divided tick, so its period is two ticks
   logic opclk_level_r, opclk_level_nxt;

   always_comb begin
      opclk_level_nxt = opclk_level_r;
      if (opclk_if.tick_out) begin
         opclk_level_nxt = ~opclk_level_r; // [RULE15]
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         opclk_level_r <= 1'b0;
      end else if (clk_en) begin
         opclk_level_r <= opclk_level_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   logic [pll_gpio_pkg::SYNC_W-1:0] pin_raw;
   logic [pll_gpio_pkg::SYNC_W-1:0] pin_lvl;

   assign pin_raw[pll_gpio_pkg::PIN_IDX_PIN1] = pin1_in;
   assign pin_raw[pll_gpio_pkg::PIN_IDX_MODE] = mode_pin;
   assign pin_raw[pll_gpio_pkg::PIN_IDX_LINE2] = line2_pin;
   assign pin_raw[pll_gpio_pkg::PIN_IDX_LINE3] = line3_pin;

   pin_sync #(
      .W(pll_gpio_pkg::SYNC_W)
   ) u_pin_sync (
      .ref_clk(ref_clk),
      .reset(reset),
      .clk_en(clk_en),
      .pin(pin_raw),
      .level(pin_lvl)
   );

   logic three_wire;
   logic pin1_lvl;
   assign three_wire = pin_lvl[pll_gpio_pkg::PIN_IDX_MODE];
   assign pin1_lvl = pin_lvl[pll_gpio_pkg::PIN_IDX_PIN1];

   // ----------------------------------------------------------------
   // Pin1 function mux
   // ----------------------------------------------------------------
   logic pin1_src;
   logic pin1_drive;

   always_comb begin
      pin1_src = 1'b0;
      pin1_drive = 1'b1;
      case (fn_sel) // [RULE8]
         pll_gpio_pkg::FN_INPUT: pin1_drive = 1'b0; // [RULE11]
         // Reserved code is kept safe by leaving the pin undriven
         pll_gpio_pkg::FN_RESERVED: pin1_drive = 1'b0;
         pll_gpio_pkg::FN_TEMP_OK: pin1_src = temp_ok;
         pll_gpio_pkg::FN_MUTE: pin1_src = auto_mute_flag;
         pll_gpio_pkg::FN_PLL_CLK: pin1_src = opclk_level_r; // [RULE15]
         pll_gpio_pkg::FN_PLL_LOCK: pin1_src = pll_lock;
         pll_gpio_pkg::FN_LOW: pin1_src = 1'b0;
         pll_gpio_pkg::FN_HIGH: pin1_src = 1'b1;
         default: pin1_drive = 1'b0;
      endcase
      if (three_wire) begin
         pin1_drive = 1'b0; // [RULE13]
      end
   end

   // Inversion last, no register, so a new setting shows in the same cycle it is stored
   assign pin1_out = pin1_drive & (pin1_src ^ fn_invert); // [RULE18] [RULE9]
   assign pin1_oe = pin1_drive;

   // ----------------------------------------------------------------
   // Pin1 as input, and the jack inputs
   // ----------------------------------------------------------------
   // Select is inactive high when pin1 is not the control select
   assign control_select_n = three_wire ? pin1_lvl : 1'b1; // [RULE12] [RULE13]
   assign jack_pin1_valid = ~three_wire & (fn_sel == pll_gpio_pkg::FN_INPUT); // [RULE12]
   assign jack_pin1 = jack_pin1_valid & pin1_lvl; // [RULE12]
   assign jack_pin2 = pin_lvl[pll_gpio_pkg::PIN_IDX_LINE2]; // [RULE14]
   assign jack_pin3 = pin_lvl[pll_gpio_pkg::PIN_IDX_LINE3]; // [RULE14]

endmodule

// >>> tb/pll_gpio_assertions.sv
// Checker for the PLL ratio and pin1 mux block
`timescale 1ns/10ps
module pll_gpio_assertions (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic clk_en,
   input wire logic reg_wr_en,
   input wire logic [6:0] reg_addr,
   input wire logic [8:0] reg_wdata,
   input wire logic pll_power_on,
   input wire logic input_halver,
   input wire logic [3:0] ratio_integer,
   input wire logic [23:0] ratio_fraction,
   input wire logic pll_ref_tick,
   input wire logic pin1_out,
   input wire logic pin1_oe,
   input wire logic control_select_n,
   input wire logic jack_pin1_valid
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (reset);
   logic wr;
   assign wr = clk_en && reg_wr_en;
   a_pll_off_quiet: assert property (!pll_power_on |-> !pll_ref_tick)
      else $error("reference tick while pll off");
   a_power_write: assert property (
      wr && reg_addr == 7'h01 |=> pll_power_on == $past(reg_wdata[5]))
      else $error("power bit not taken");
   a_ratio_write: assert property (
      wr && reg_addr == 7'h24 |=> {input_halver, ratio_integer} == $past(reg_wdata[4:0]))
      else $error("ratio register not taken");
   a_frac_high: assert property (
      wr && reg_addr == 7'h25 |=> ratio_fraction[23:18] == $past(reg_wdata[5:0]))
      else $error("fraction high bits wrong");
   a_ref_every: assert property (
      clk_en && pll_power_on && !input_halver |-> pll_ref_tick)
      else $error("reference tick missing");
   a_ref_halved: assert property (
      clk_en && pll_power_on && input_halver && pll_ref_tick
      ##1 clk_en && pll_power_on && input_halver |-> !pll_ref_tick)
      else $error("halved reference tick too often");
   a_select_input: assert property (!control_select_n |-> !pin1_oe)
      else $error("pin1 driven in three wire mode");
   a_input_default: assert property (jack_pin1_valid |-> !pin1_oe && !pin1_out)
      else $error("pin1 driven while input");
   a_undriven_low: assert property (!pin1_oe |-> !pin1_out)
      else $error("pin1 level while undriven");
endmodule
bind pll_ratio_and_gpio_pin_mux pll_gpio_assertions chk (.ref_clk, .reset, .clk_en,
   .reg_wr_en, .reg_addr, .reg_wdata, .pll_power_on, .input_halver, .ratio_integer,
   .ratio_fraction, .pll_ref_tick, .pin1_out, .pin1_oe, .control_select_n, .jack_pin1_valid);

// >>> tb/pll_model.sv
// Behavioural PLL standing beside the block
`timescale 1ns/10ps
module pll_model #(
   parameter int LOCK_TICKS = 8
) (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic pll_power_on,
   input wire logic pll_ref_tick,
   input wire logic slow,
   output logic pll_out_tick,
   output logic pll_lock
);
   int cnt;
   logic ph;
   // Power off clears the lock count at the next clock edge, so a stale lock can reach pin1 for one cycle
   always_ff @(posedge ref_clk) begin
      if (reset || !pll_power_on) begin
         cnt <= 0;
         ph <= 1'b0;
      end else begin
         ph <= !ph;
         if (pll_ref_tick && cnt < LOCK_TICKS)
            cnt <= cnt + 1;
      end
   end
   // Slow gives half the output edges, as a lower ratio would
   assign pll_out_tick = pll_power_on && (!slow || ph);
   assign pll_lock = cnt == LOCK_TICKS;
endmodule

// >>> tb/testbench.sv
// Self-checking bench for the PLL ratio and pin1 mux block
`timescale 1ns/10ps
module testbench;
   logic ref_clk = 1'b0, reset = 1'b1, clk_en = 1'b1, reg_wr_en = 1'b0, reg_rd_en = 1'b0;
   logic temp_ok = 1'b0, auto_mute_flag = 1'b0, pin1_in = 1'b0, mode_pin = 1'b0;
   logic line2_pin = 1'b0, line3_pin = 1'b0, slow = 1'b0, rd_d = 1'b0;
   logic [6:0] reg_addr = 7'h00;
   logic [8:0] reg_wdata = 9'h000;
   logic pll_out_tick, pll_lock, pll_power_on, input_halver, pll_ref_tick, core_clock_source;
   logic system_clock_tick, pin1_out, pin1_oe, control_select_n, jack_pin1, jack_pin1_valid;
   logic jack_pin2, jack_pin3, lv, oe;
   logic [8:0] reg_rdata;
   logic [3:0] ratio_integer, ri;
   logic [23:0] ratio_fraction;
   logic [8:0] exp_q[$];
   logic [8:0] f[3];
   logic [2:0] c;
   logic [6:0] ra[8] = '{7'h01, 7'h06, 7'h08, 7'h24, 7'h25, 7'h26, 7'h27, 7'h02};
   logic [8:0] rv[8] = '{9'h000, 9'h140, 9'h000, 9'h008, 9'h00c, 9'h093, 9'h0e9, 9'h000};
   int r2[8] = '{2, 3, 4, 6, 8, 12, 16, 24};
   int bad_count = 0, checks_done = 0, n;
   always #20 ref_clk = ~ref_clk;
   pll_ratio_and_gpio_pin_mux dut (.ref_clk, .reset, .clk_en, .reg_wr_en, .reg_rd_en, .reg_addr,
      .reg_wdata, .reg_rdata, .pll_power_on, .input_halver, .ratio_integer, .ratio_fraction,
      .pll_ref_tick, .pll_out_tick, .pll_lock, .temp_ok, .auto_mute_flag, .core_clock_source,
      .system_clock_tick, .pin1_in, .pin1_out, .pin1_oe, .mode_pin, .line2_pin, .line3_pin,
      .control_select_n, .jack_pin1, .jack_pin1_valid, .jack_pin2, .jack_pin3);
   pll_model pll (.ref_clk, .reset, .pll_power_on, .pll_ref_tick, .slow, .pll_out_tick,
      .pll_lock);
   task automatic check(input string nm, input logic [23:0] got, input logic [23:0] exp);
      checks_done++;
      if (got !== exp) begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic complete_run();
      if (bad_count == 0 && checks_done > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   // A read notes its expected data; the monitor below compares it a cycle later
   task automatic xfer(input logic w, input logic [6:0] a, input logic [8:0] d);
      @(negedge ref_clk);
      {reg_wr_en, reg_rd_en, reg_addr, reg_wdata} = {w, !w, a, d};
      if (!w) exp_q.push_back(d);
      @(negedge ref_clk);
      {reg_wr_en, reg_rd_en} = 2'b00;
   endtask
   // Span of two intervals skips the first event, which may follow a ratio change
   task automatic gap(input logic pin, output int n);
      int t[$];
      logic last;
      last = pin1_out;
      for (int k = 0; k < 400 && t.size() < 4; k++) begin
         @(negedge ref_clk);
         if (pin ? pin1_out !== last : system_clock_tick === 1'b1) t.push_back(k);
         last = pin1_out;
      end
      n = t.size() == 4 ? t[3] - t[1] : 0;
   endtask
   task automatic ticks(output int n);
      n = 0;
      repeat (8) begin
         @(negedge ref_clk);
         n += (pll_ref_tick !== 1'b0);
      end
   endtask
   always @(posedge ref_clk) rd_d <= reg_rd_en && clk_en;
   always @(negedge ref_clk) begin
      if (rd_d) check("reg_rdata", reg_rdata, exp_q.pop_front());
   end
   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   initial begin
      void'($urandom(96));
      repeat (4) @(negedge ref_clk);
      reset = 1'b0;
      foreach (ra[i]) xfer(1'b0, ra[i], rv[i]);
      check("fraction", ratio_fraction, 24'h31_26e9);
      check("cfg", {pll_power_on, input_halver, ratio_integer, core_clock_source}, 7'h11);
      ticks(n);
      check("ticks off", n, 0);
      check("pin reset", {pin1_oe, pin1_out, control_select_n, jack_pin1_valid}, 4'h3);
      for (int r = 0; r < 3; r++) begin
         f[r] = 9'($urandom);
         xfer(1'b1, 7'(7'h25 + r), f[r]);
      end
      ri = 4'(6 + $urandom % 7);
      xfer(1'b1, 7'h24, {5'h00, ri});
      check("fraction", ratio_fraction, {f[0][5:0], f[1], f[2]});
      check("integer", ratio_integer, ri);
      xfer(1'b0, 7'h25, f[0]);
      xfer(1'b1, 7'h01, 9'h020);
      ticks(n);
      check("ticks", n, 8);
      clk_en = 1'b0;
      xfer(1'b1, 7'h01, 9'h000);
      check("frozen", {pll_power_on, pll_ref_tick}, 2'h3);
      clk_en = 1'b1;
      xfer(1'b1, 7'h24, 9'h018);
      ticks(n);
      check("ticks half", n, 4);
      xfer(1'b1, 7'h24, 9'h008);
      for (int i = 0; i < 8; i++) begin
         xfer(1'b1, 7'h06, {1'b0, 3'(i), 5'h00});
         gap(1'b0, n);
         check("system_clock", n, r2[i]);
      end
      xfer(1'b1, 7'h06, 9'h140);
      gap(1'b0, n);
      check("system_clock pll", n, 16);
      for (int i = 0; i < 16; i++) begin
         {temp_ok, auto_mute_flag} = 2'($urandom);
         xfer(1'b1, 7'h08, {5'h00, 4'(i)});
         c = 3'(i);
         lv = c == 3'h2 ? temp_ok : c == 3'h3 ? auto_mute_flag : c == 3'h5 || c == 3'h7;
         oe = c > 3'h1;
         check("pin1", {pin1_oe, jack_pin1_valid, pin1_out & (c != 3'h4)},
            {oe, c == 3'h0, oe & (lv ^ i[3]) & (c != 3'h4)});
      end
      for (int d = 0; d < 4; d++) begin
         xfer(1'b1, 7'h08, {3'h0, 2'(d), 4'h4});
         gap(1'b1, n);
         check("pin1 clock", n, 8 * (d + 1));
      end
      slow = 1'b1;
      gap(1'b1, n);
      check("pin1 slow", n, 64);
      slow = 1'b0;
      mode_pin = 1'b1;
      xfer(1'b1, 7'h08, 9'h007);
      for (int k = 0; k < 4; k++) begin
         {pin1_in, line2_pin, line3_pin} = {k[0], 2'($urandom)};
         repeat (6) @(negedge ref_clk);
         check("three wire", {pin1_oe, control_select_n, jack_pin1_valid, jack_pin1,
            jack_pin2, jack_pin3}, {1'b0, pin1_in, 2'b00, line2_pin, line3_pin});
      end
      mode_pin = 1'b0;
      xfer(1'b1, 7'h08, 9'h000);
      repeat (6) @(negedge ref_clk);
      check("jack", {control_select_n, jack_pin1, jack_pin1_valid}, {1'b1, pin1_in, 1'b1});
      complete_run();
   end
   initial begin
      repeat (20000) @(posedge ref_clk);
      bad_count++;
      complete_run();
   end
endmodule
